// ==== design/adc_serial_rate_select_port.sv ====
// Serial readout and rate selection port of a delta-sigma converter
// Overview of operation
// - SDI held low gives ratio 256
// - SDI held high gives ratio 32768
// - Level changes outside readout apply next conversion
// - Late low-to-high captures code 00111, 55Hz
// - Change before first rise applies fully
// - Change after fifth rise applies one later
// - Serial code shifted in during readout
// - Five-bit code decoded to oversampling ratio
// - Busy high converting, low until readout ends
// - Clock source select low means external clock
// - Data out tristate; else shows end flag
// - Conversion end enters sleep regardless of select
// - Sleep holds result until first clock rise
// - Bits change on falling, host latches rising
// - 32nd falling edge starts conversion, outputs high
// - Select rise after fifth fall aborts readout
// - Result loaded at end-of-conversion falling edge
// - Frame: flag, filler, polarity, result, sub bits
`timescale 1ns/1ps
module adc_serial_rate_select_port
    import adc_rate_port_pkg::*;
#(
    parameter int unsigned OSR_UNIT = OSR_UNIT_CYCLES
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    input  wire logic        clock_source_select,
    output logic             sdo,
    output logic             sdo_oe,
    output logic             busy,
    input  wire logic        sample_valid,
    output logic             sample_ready,
    input  wire sample_t     sample_data,
    output logic             conv_start,
    output logic [15:0]      osr_value
);

    logic [SYNC_WIDTH-1:0] pins_s;       // Synchronised pins
    logic                  sck_s;        // Serial clock, core domain
    logic                  cs_n_s;       // Chip select, core domain
    logic                  sdi_s;        // Data input, core domain
    logic                  ext_s;        // Clock source select, core domain
    logic                  sck_d;        // Delayed clock for edges
    logic                  cs_n_d;       // Delayed select for edges
    logic                  sck_rise;
    logic                  sck_fall;
    logic                  cs_rise;
    logic                  link_on;      // External clock mode active
    conv_state_t           state;        // Converter state
    logic [31:0]           conv_cnt;     // Cycles into conversion
    logic [31:0]           conv_len;     // Cycles per conversion
    logic                  conv_done;
    logic [5:0]            rise_cnt;     // Rising edges this readout, counted up to five
    logic [5:0]            fall_cnt;     // Falling edges this readout
    logic [4:0]            code_shift;   // Code being shifted in
    logic [4:0]            pending_code; // Code for next conversion
    logic [4:0]            active_code;  // Code of running conversion
    logic [FRAME_BITS-1:0] shift_reg;    // Static output register
    logic                  rise_take;
    logic                  fall_take;
    logic                  last_fall;
    logic                  abort;
    logic                  start_conv;
    logic                  buf_valid;
    logic                  load_frame;
    sample_t               buf_data;
    frame_t                new_frame;

    // Bring the pins into the core clock domain
    pin_sync #(
        .WIDTH    (SYNC_WIDTH)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({clock_source_select, sdi, ~cs_n, sck}),
        .sync_out (pins_s)
    );

    assign sck_s  = pins_s[SYN_SCK];
    assign cs_n_s = ~pins_s[SYN_CS];   // Slot carries select active high, so reset reads deselected
    assign sdi_s  = pins_s[SYN_SDI];
    assign ext_s  = pins_s[SYN_EXT];

    // Results wait here until a conversion ends
    sample_buffer #(
        .WIDTH     ($bits(sample_t)),
        .DEPTH     (2)
    ) u_buf (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_data),
        .out_valid (buf_valid),
        .out_ready (load_frame),
        .out_data  (buf_data)
    );

    // Edge history of clock and select
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            sck_d  <= 1'b0;
            cs_n_d <= 1'b1;
        end
        else
        begin
            sck_d  <= sck_s;
            cs_n_d <= cs_n_s;
        end
    end

    // Serial clock only honoured in external clock mode
    assign link_on  = ~ext_s;
    assign sck_rise = link_on & sck_s & ~sck_d;
    assign sck_fall = link_on & ~sck_s & sck_d;
    assign cs_rise  = cs_n_s & ~cs_n_d;

    // Rising edges with select low sample the code
    assign rise_take = sck_rise & ~cs_n_s & (state != ST_CONVERT)
                       & (rise_cnt < CODE_EDGES);
    // Falling edges with select low move the frame
    assign fall_take = sck_fall & ~cs_n_s & (state == ST_OUTPUT);
    assign last_fall = fall_take & (fall_cnt == LAST_FALL);
    assign abort     = (state == ST_OUTPUT) & cs_rise
                       & (fall_cnt >= ABORT_MIN_FALLS);
    assign start_conv = last_fall | abort;

    // Conversion ends only when a result is ready to load
    assign conv_len   = 32'(osr_value * OSR_UNIT);
    assign conv_done  = (state == ST_CONVERT) & (conv_cnt >= conv_len - 32'h1);
    assign load_frame = conv_done & buf_valid;

    // Frame layout of the loaded result: flag low, filler low, then the sample
    assign new_frame = {1'b0, 1'b0, buf_data};

    // Decode of the five-bit code into a ratio
    function automatic logic [15:0] decode_osr(input logic [4:0] code);
        if (code == 5'h00)
            decode_osr = 16'h0100;
        else
        begin
            case (code[3:0])
                4'h1:    decode_osr = 16'h0040;
                4'h2:    decode_osr = 16'h0080;
                4'h3:    decode_osr = 16'h0100;
                4'h4:    decode_osr = 16'h0200;
                4'h5:    decode_osr = 16'h0400;
                4'h6:    decode_osr = 16'h0800;
                4'h7:    decode_osr = 16'h1000;
                4'h8:    decode_osr = 16'h2000;
                4'h9:    decode_osr = 16'h4000;
                4'hF:    decode_osr = 16'h8000;
                default: decode_osr = OSR_DEFAULT;
            endcase
        end
    endfunction : decode_osr

    // Converter state sequence
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            state <= ST_CONVERT;
        else
        begin
            case (state)
                ST_CONVERT:
                    if (load_frame)
                        state <= ST_SLEEP;
                ST_SLEEP:
                    if (rise_take)
                        state <= ST_OUTPUT;
                ST_OUTPUT:
                    if (start_conv)
                        state <= ST_CONVERT;
                default:
                    state <= ST_CONVERT;
            endcase
        end
    end

    // Conversion timer and start pulse
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            conv_cnt   <= '0;
            conv_start <= 1'b1;
        end
        else
        begin
            conv_start <= start_conv;
            if (start_conv)
                conv_cnt <= '0;
            else if (state == ST_CONVERT && !conv_done)
                conv_cnt <= conv_cnt + 32'h1;
        end
    end

    // Edge counters of one readout
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rise_cnt <= '0;
            fall_cnt <= '0;
        end
        else if (start_conv || state == ST_CONVERT)
        begin
            rise_cnt <= '0;
            fall_cnt <= '0;
        end
        else
        begin
            if (rise_take)
                rise_cnt <= rise_cnt + 6'h01;
            if (fall_take)
                fall_cnt <= fall_cnt + 6'h01;
        end
    end

    // Rate code capture, level or serial alike
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            code_shift   <= CODE_RESET;
            pending_code <= CODE_RESET;
        end
        else if (rise_take)
        begin
            code_shift <= {code_shift[3:0], sdi_s};
            // Fifth rise completes the code for the next conversion
            if (rise_cnt == CODE_EDGES - 6'h01)
                pending_code <= {code_shift[3:0], sdi_s};
        end
    end

    // Code and its ratio go live only as a conversion starts
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            active_code <= CODE_RESET;
            osr_value   <= OSR_DEFAULT;
        end
        else if (start_conv)
        begin
            active_code <= pending_code;
            osr_value   <= decode_osr(pending_code);
        end
    end

    // Busy indicator
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            busy <= 1'b1;
        else if (start_conv)
            busy <= 1'b1;
        else if (load_frame)
            busy <= 1'b0;
    end

    // Static shift register and data output bit
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            shift_reg <= '0;
            sdo       <= 1'b1;
        end
        else if (start_conv)
            sdo <= 1'b1;
        else if (load_frame)
        begin
            shift_reg <= new_frame;
            sdo       <= 1'b0;
        end
        else if (fall_take)
        begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], 1'b0};
            sdo       <= shift_reg[FRAME_BITS-2];
        end
    end

    // Driver enabled only while selected
    assign sdo_oe = ~cs_n_s;

    // Checks on the design's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_started;
        busy && sdo && (state == ST_CONVERT) ##1 (conv_cnt == 32'h1 || conv_len == 32'h1);
    endsequence

    property p_end_of_frame;
        last_fall |=> s_started;
    endproperty
    a_end_of_frame: assert property (p_end_of_frame) else $error("frame end did not restart");

    property p_busy_low_sleep;
        (state == ST_SLEEP || state == ST_OUTPUT) |-> !busy;
    endproperty
    a_busy_low_sleep: assert property (p_busy_low_sleep) else $error("busy high after conversion");

    property p_busy_high_convert;
        (state == ST_CONVERT) |-> busy;
    endproperty
    a_busy_high_convert: assert property (p_busy_high_convert) else $error("busy low while converting");

    property p_tristate;
        cs_n_s |-> !sdo_oe;
    endproperty
    a_tristate: assert property (p_tristate) else $error("data driven while deselected");

    property p_flag_shown;
        (state == ST_CONVERT) && !cs_n_s |-> sdo_oe && sdo;
    endproperty
    a_flag_shown: assert property (p_flag_shown) else $error("end flag not high while converting");

    property p_sleep_entry;
        load_frame |=> (state == ST_SLEEP) && !sdo && !shift_reg[FRAME_BITS-1] && !shift_reg[FRAME_BITS-2];
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

    property p_sleep_hold;
        (state == ST_SLEEP) && !rise_take |=> (state == ST_SLEEP) && $stable(shift_reg);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left without clock rise");

    property p_abort;
        abort |=> (state == ST_CONVERT) && busy && (active_code == $past(pending_code));
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not restart");

    property p_no_early_abort;
        (state == ST_OUTPUT) && cs_rise && (fall_cnt < ABORT_MIN_FALLS) && !fall_take |=> state == ST_OUTPUT;
    endproperty
    a_no_early_abort: assert property (p_no_early_abort) else $error("early abort honoured");

    property p_code_capture;
        rise_take && (rise_cnt == 6'h04) |=> pending_code == {$past(code_shift[3:0]), $past(sdi_s)};
    endproperty
    a_code_capture: assert property (p_code_capture) else $error("rate code not captured");

    property p_zero_code;
        (active_code == 5'h00) |-> osr_value == 16'h0100;
    endproperty
    a_zero_code: assert property (p_zero_code) else $error("zero code not ratio 256");

    property p_ones_code;
        (active_code == 5'h1F) |-> osr_value == 16'h8000;
    endproperty
    a_ones_code: assert property (p_ones_code) else $error("all ones not ratio 32768");

endmodule : adc_serial_rate_select_port

// ==== common/adc_rate_port_pkg.sv ====
// Shared constants and frame types for the converter serial readout port
package adc_rate_port_pkg;

    // Core clock and nominal modulator oscillator rates
    localparam int unsigned CORE_CLK_HZ     = 250_000_000;
    localparam int unsigned MOD_OSC_HZ      = 1_800_000;
    // Modulator samples per output word are eight times the ratio
    localparam int unsigned SAMPLES_PER_OSR = 8;
    // Core cycles spent per unit of oversampling ratio
    localparam int unsigned OSR_UNIT_CYCLES = (SAMPLES_PER_OSR * CORE_CLK_HZ) / MOD_OSC_HZ;

    // Frame geometry
    localparam int unsigned FRAME_BITS      = 32;
    localparam int unsigned RESULT_BITS     = 24;
    localparam int unsigned SUB_BITS        = 5;
    localparam int unsigned CODE_BITS       = 5;
    localparam int unsigned SYNC_WIDTH      = 4;

    // Edge counts within one output cycle
    localparam logic [5:0]  CODE_EDGES      = 6'h05;
    localparam logic [5:0]  LAST_FALL       = 6'h1F;
    localparam logic [5:0]  ABORT_MIN_FALLS = 6'h05;

    // Values after reset
    localparam logic [4:0]  CODE_RESET      = 5'h00;
    localparam logic [15:0] OSR_DEFAULT     = 16'h0100;

    // Pin slots on the synchroniser
    localparam int unsigned SYN_SCK         = 0;
    localparam int unsigned SYN_CS          = 1;
    localparam int unsigned SYN_SDI         = 2;
    localparam int unsigned SYN_EXT         = 3;

    // Converter states, one bit changes from convert to sleep to output, both bits on return to convert
    typedef enum logic [1:0] {
        ST_CONVERT = 2'b00,
        ST_SLEEP   = 2'b01,
        ST_OUTPUT  = 2'b11
    } conv_state_t;

    // One result from the filter
    typedef struct packed {
        logic                     polarity_bit;
        logic [RESULT_BITS-1:0]   result;
        logic [SUB_BITS-1:0]      sub_lsb;
    } sample_t;

    // One 32-bit output frame, first bit on top
    typedef struct packed {
        logic     eoc_n;
        logic     filler_bit;
        sample_t  body;
    } frame_t;

endpackage : adc_rate_port_pkg

// ==== design/pin_sync.sv ====
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync
    import adc_rate_port_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;   // First stage, read only by second stage

    // One pair of flops per pin
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    meta[i]     <= 1'b0;
                    sync_out[i] <= 1'b0;
                end
                else
                begin
                    meta[i]     <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule : pin_sync

// ==== design/sample_buffer.sv ====
// Small valid/ready buffer holding filter results
`timescale 1ns/1ps
module sample_buffer
    import adc_rate_port_pkg::*;
#(
    parameter int unsigned WIDTH = 30,
    parameter int unsigned DEPTH = 2
)
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];   // Storage entries
    logic [PW-1:0]    wr_ptr;        // Next slot to fill
    logic [PW-1:0]    rd_ptr;        // Oldest slot
    logic [PW:0]      count;         // Entries held
    logic             push;
    logic             pop;

    // Honest full and empty
    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr];

    // Storage write
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // Pointers and occupancy
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

endmodule : sample_buffer

// ==== tb/host_model.sv ====
// Host serial master model driving the converter readout pins
`timescale 1ns/1ps
module host_model
#(
    parameter int HALF_NS = 80
)
(
    output logic      sck,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo_line
);

    // Idle pins: clock parked low between frames, select released
    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    // One readout: code bits on rises 1..5, tail level after, aborts if short
    task automatic xfer(input logic [4:0] code, input logic tail, input int nbits, output logic [31:0] data);
        data = '0;
        cs_n = 1'b0;
        sdi  = code[4];
        #(HALF_NS);
        for (int i = 0; i < nbits; i++)
        begin
            sck  = 1'b1;
            data = {data[30:0], sdo_line};
            #(HALF_NS);
            sck  = 1'b0;
            sdi  = (i < 4) ? code[3 - i] : tail;
            #(HALF_NS);
        end
        // Short frames end by raising select, never before five bits
        if (nbits < 32 && nbits >= 5)
            cs_n = 1'b1;
    endtask : xfer

endmodule : host_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the converter serial readout port
`timescale 1ns/1ps
module tb_top;
    import adc_rate_port_pkg::*;

    localparam int unsigned OSR_U = 1; // One core cycle per ratio unit
    logic        core_clk;
    logic        rst_n;
    logic        sck;
    logic        cs_n;
    logic        sdi;
    logic        clock_source_select;
    logic        sdo;
    logic        sdo_oe;
    logic        busy;
    logic        sample_valid;
    logic        sample_ready;
    sample_t     sample_data;
    logic        conv_start;
    logic [15:0] osr_value;
    logic [31:0] got;
    int          failures;
    int          comparisons;
    int          seen_start;
    int          nsamp;
    sample_t     exp_q[$];
    logic [4:0]  codes[10] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h11, 5'h0A};
    logic [15:0] ratios[10] = '{16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h2000,
                                16'h4000, 16'h0040, 16'h0100};
    wire         sdo_line = sdo_oe ? sdo : 1'b1; // Pull-up while released

    adc_serial_rate_select_port #(.OSR_UNIT(OSR_U)) u_adc_serial_rate_select_port (
        .core_clk(core_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .sdi(sdi),
        .clock_source_select(clock_source_select), .sdo(sdo), .sdo_oe(sdo_oe), .busy(busy),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
        .conv_start(conv_start), .osr_value(osr_value));

    host_model u_host_model (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line));

    // Core clock, 4 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Count start pulses
    always @(posedge core_clk)
        if (conv_start === 1'b1)
            seen_start++;

    // Compare and report
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Counts, verdict, end of run
    task automatic finish_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // Push one result word through the valid/ready handshake
    task automatic push;
        int n;
        @(posedge core_clk);
        #1;
        sample_valid = 1'b1;
        sample_data  = sample_t'(30'h2AAAAAAA ^ (30'(nsamp) * 30'h0123457));
        n = 0;
        while (sample_ready !== 1'b1 && n < 50000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        exp_q.push_back(sample_data);
        nsamp++;
        #1 sample_valid = 1'b0;
    endtask : push

    // Bounded wait for sleep
    task automatic wait_sleep;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 40000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("busy in sleep", busy, 1'b0);
    endtask : wait_sleep

    // One readout: frame, restart, ratio of the new conversion
    task automatic readout(input string name, input logic [4:0] code, input logic tail, input int nbits,
                           input logic [15:0] exp_osr);
        logic [31:0] want;
        wait_sleep();
        want = {2'b00, exp_q.pop_front()};
        seen_start = 0;
        u_host_model.xfer(code, tail, nbits, got);
        check({name, " frame"}, got, want >> (32 - nbits));
        repeat (8) @(posedge core_clk);
        #1;
        check({name, " busy"}, busy, 1'b1);
        check({name, " sdo"}, nbits == 32 ? sdo_line : !sdo_oe, 1'b1);
        check({name, " start"}, seen_start, 1);
        check({name, " ratio"}, osr_value, exp_osr);
        push();
        $display("done %s", name);
    endtask : readout

    // Watchdog well past the expected run length
    initial
    begin
        #380000;
        failures++;
        $display("BAD watchdog expected done seen timeout");
        finish_test();
    end

    // Test sequence
    initial
    begin
        rst_n = 1'b0;
        clock_source_select = 1'b0;
        sample_valid = 1'b0;
        sample_data = '0;
        failures = 0;
        comparisons = 0;
        nsamp = 0;
        repeat (10) @(posedge core_clk);
        #1 rst_n = 1'b1;
        check("busy after reset", busy, 1'b1);
        check("ratio after reset", osr_value, 16'h0100);
        push();
        push();
        #1 check("buffer full", sample_ready, 1'b0);
        $display("done buffer fill");
        readout("level low", 5'h00, 1'b0, 32, 16'h0100);
        readout("rise after fifth", 5'h00, 1'b1, 32, 16'h0100);
        readout("level high", 5'h1F, 1'b1, 32, 16'h8000);
        readout("low before first", 5'h00, 1'b0, 32, 16'h0100);
        readout("late rise", 5'h07, 1'b1, 32, 16'h1000);
        for (int i = 0; i < 10; i++)
            readout("code", codes[i], 1'b0, 6, ratios[i]);
        wait_sleep();
        clock_source_select = 1'b1;
        u_host_model.xfer(5'h00, 1'b0, 6, got);
        check("blocked link", busy, 1'b0);
        check("blocked frame", got, 32'h0);
        clock_source_select = 1'b0;
        $display("done clock source");
        finish_test();
    end

endmodule : tb_top
